//--- core/pts_regs.vh
// Purpose: register map, field positions and reset values of the period timer
// Assumes: register index times four gives the wishbone byte address
// Notes:   definitions only
`ifndef PTS_REGS_VH
`define PTS_REGS_VH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define PTS_IDX_FLAGS    8'h0c
`define PTS_IDX_COUNT    8'h11
`define PTS_IDX_CTRL     8'h12
`define PTS_IDX_ENABLES  8'h8c
`define PTS_IDX_LIMIT    8'h92

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PTS_FLAG_BIT     1
`define PTS_RUN_BIT      2
`define PTS_PRE_LSB      0
`define PTS_POST_LSB     3
`define PTS_CTRL_MASK    8'h7f

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PTS_RST_COUNT    8'h00
`define PTS_RST_CTRL     8'h00
`define PTS_RST_LIMIT    8'hff
`define PTS_RST_FLAGS    8'h00
`define PTS_RST_ENABLES  8'h00

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define PTS_INSTR_DIV    3'h4
`define PTS_PRE_DIV1     5'h01
`define PTS_PRE_DIV4     5'h04
`define PTS_PRE_DIV16    5'h10

`endif

//--- core/pts_timer.v
// Purpose: 8-bit period timer with prescaler, postscaler and wishbone registers
// Assumes: clk_i is the oscillator clock; the count ticks at clk_i / 4 divided by the prescale ratio
// Notes:   registers sit at byte address 4 * index, data in bits 7:0
//
// The Wishbone slave port was decided locally.
`timescale 1ns/10ps
`include "pts_regs.vh"

// Overview of operation
// - 8-bit counter on instruction clock, scaled both sides
// - prescale select bits 1:0 give 1, 4, 16
// - count up to limit, then wrap to zero
// - period limit resets to all ones
// - postscaler completion sets match flag, flags bit 1
// - postscale select bits 6:3 divide by value+1
// - run bit 2 gates counting
// - count/control writes and reset clear both scalers
// - control write leaves the count unchanged
// - count resets to zero, software read/write
// - raw match pulse output for serial port
// - count and match offered as pwm time base
// - control bit 7 reads zero, resets to zero
// - limit read/write, new value used at once
module pts_timer #(
    parameter ADR_W = 10
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             ce_i,
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [ADR_W-1:0] wb_adr_i,
    input  wire [31:0]      wb_dat_i,
    input  wire [3:0]       wb_sel_i,
    output wire [31:0]      wb_dat_o,
    output wire             wb_ack_o,
    output wire             irq_o,
    output wire             match_o,
    output wire [7:0]       count_o,
    output wire [7:0]       limit_o
);

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg  [7:0] count_r;
    reg  [7:0] ctrl_r;
    reg  [7:0] limit_r;
    reg        flag_r;
    reg        irq_en_r;
    reg  [1:0] phase_r;
    reg  [4:0] pre_cnt_r;
    reg  [3:0] post_cnt_r;
    reg        match_r;
    reg        ack_r;
    reg  [7:0] rdat_r;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire [7:0] idx    = wb_adr_i[9:2];
    wire       req    = wb_cyc_i & wb_stb_i;
    wire       wr_en  = req & ack_r & wb_we_i & wb_sel_i[0];
    wire       wr_cnt = wr_en & (idx == `PTS_IDX_COUNT);
    wire       wr_ctl = wr_en & (idx == `PTS_IDX_CTRL);
    wire       wr_lim = wr_en & (idx == `PTS_IDX_LIMIT);
    wire       wr_flg = wr_en & (idx == `PTS_IDX_FLAGS);
    wire       wr_ena = wr_en & (idx == `PTS_IDX_ENABLES);

    // prescale ratio from the select field
    function [4:0] pre_div;
        input [1:0] sel;
        begin
            case (sel)
                2'h0:    pre_div = `PTS_PRE_DIV1;
                2'h1:    pre_div = `PTS_PRE_DIV4;
                default: pre_div = `PTS_PRE_DIV16;
            endcase
        end
    endfunction

    function [7:0] read_mux;
        input [7:0] sel;
        begin
            case (sel)
                `PTS_IDX_FLAGS:   read_mux = {6'h00, flag_r, 1'b0};
                `PTS_IDX_COUNT:   read_mux = count_r;
                `PTS_IDX_CTRL:    read_mux = ctrl_r & `PTS_CTRL_MASK;
                `PTS_IDX_ENABLES: read_mux = {6'h00, irq_en_r, 1'b0};
                `PTS_IDX_LIMIT:   read_mux = limit_r;
                default:          read_mux = 8'h00;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // timer datapath
    // ------------------------------------------------------------------------
    wire       run      = ctrl_r[`PTS_RUN_BIT];
    wire [3:0] post_sel = ctrl_r[`PTS_POST_LSB+3:`PTS_POST_LSB];
    wire [1:0] pre_sel  = ctrl_r[`PTS_PRE_LSB+1:`PTS_PRE_LSB];
    wire       tick     = (phase_r == 2'h3);
    wire       inc      = run & tick &
                          (pre_cnt_r == pre_div(pre_sel) - 5'h01);
    wire       hit      = inc & (count_r == limit_r);
    wire       post_done = hit & (post_cnt_r == post_sel);
    wire       scl_clr  = wr_cnt | wr_ctl;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_r    <= `PTS_RST_COUNT;
            ctrl_r     <= `PTS_RST_CTRL;
            limit_r    <= `PTS_RST_LIMIT;
            flag_r     <= 1'b0;
            irq_en_r   <= 1'b0;
            phase_r    <= 2'h0;
            pre_cnt_r  <= 5'h00;
            post_cnt_r <= 4'h0;
            match_r    <= 1'b0;
            ack_r      <= 1'b0;
            rdat_r     <= 8'h00;
        end else if (ce_i) begin
            phase_r <= phase_r + 2'h1;
            ack_r   <= req & ~ack_r;
            if (req & ~ack_r)
                rdat_r <= read_mux(idx);
            match_r <= hit;
            if (wr_ctl)
                ctrl_r <= wb_dat_i[7:0] & `PTS_CTRL_MASK;
            if (wr_lim)
                limit_r <= wb_dat_i[7:0];
            if (wr_ena)
                irq_en_r <= wb_dat_i[`PTS_FLAG_BIT];
            if (wr_cnt)
                count_r <= wb_dat_i[7:0];
            else if (hit)
                count_r <= 8'h00;
            else if (inc)
                count_r <= count_r + 8'h01;
            if (scl_clr) begin
                pre_cnt_r  <= 5'h00;
                post_cnt_r <= 4'h0;
            end else if (run & tick) begin
                pre_cnt_r <= inc ? 5'h00 : pre_cnt_r + 5'h01;
                if (hit)
                    post_cnt_r <= post_done ? 4'h0 : post_cnt_r + 4'h1;
            end
            // a completion in the clearing cycle wins over the clear
            if (post_done)
                flag_r <= 1'b1;
            else if (wr_flg & wb_dat_i[`PTS_FLAG_BIT])
                flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h000000, rdat_r};
    assign irq_o    = flag_r & irq_en_r;
    assign match_o  = match_r;
    assign count_o  = count_r;
    assign limit_o  = limit_r;

endmodule // pts_timer

//--- tb/pts_timer_props.sv
// Purpose: port checks of pts_timer
// Assumes: ce_i low only while the bus is idle
// Notes:   bound below
`timescale 1ns/10ps
module pts_props (
    input wire        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, match_o,
    input wire [31:0] wb_dat_o,
    input wire [7:0]  count_o, limit_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    ack_due_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    dat_high_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("high data");
    rst_val_a: assert property ($fell(rst_i) |-> count_o == 8'h00 && limit_o == 8'hff)
        else $error("reset value");
    cnt_step_a: assert property (!$stable(count_o) |-> count_o == $past(count_o) + 8'h01
        || count_o == 8'h00 || $past(wb_ack_o)) else $error("count jump");
    lim_hold_a: assert property (!$stable(limit_o) |-> $past(wb_ack_o)) else $error("limit moved");
    match_once_a: assert property (match_o |=> !match_o) else $error("match held");
    match_zero_a: assert property (match_o |-> count_o == 8'h00) else $error("match off zero");
endmodule // pts_props
bind pts_timer pts_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .match_o(match_o), .wb_dat_o(wb_dat_o), .count_o(count_o), .limit_o(limit_o));

//--- tb/pts_timer_tb.sv
// Purpose: self-checking bench of pts_timer
// Assumes: wb_sel_i tied high; ce_i dropped only while the bus is idle
// Notes:   rates timed between match pulses
`timescale 1ns/10ps
module pts_timer_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, we = 1'b0, ce = 1'b1;
    logic [9:0]  adr = 10'h0;
    logic [31:0] wd = 32'h0;
    wire  [31:0] rdat;
    wire         ack, irq, match;
    wire  [7:0]  cnt, lim;
    int          bad_count, checks;
    pts_timer u_pts_timer (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .match_o(match), .count_o(cnt), .limit_o(lim));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic cmp(input logic [7:0] g, e);
        checks++;
        bad_count += int'(g !== e);
        if (g !== e) $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    endtask
    task automatic wb(input logic [7:0] i, input logic w, input logic [7:0] d);
        int n = 0;
        @(posedge clk_i);
        {req, we, adr, wd} <= {1'b1, w, i, 2'b00, 24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 99);
        req <= 1'b0;
        if (n > 98) bad_count++;
        if (!w) cmp(rdat[7:0], d);
    endtask
    task automatic wm;
        @(posedge clk_i);
        while (match !== 1'b1) @(posedge clk_i);
    endtask
    task automatic gap(input logic [7:0] e);
        int n = 1;
        wm;
        do @(posedge clk_i); while (match !== 1'b1 && ++n < 999);
        cmp(8'(n), e);
    endtask
    task automatic s_regs;
        wb(8'h92, 1'b0, 8'hff);
        wb(8'h40, 1'b0, 8'h00);
        wb(8'h11, 1'b1, 8'h5a);
        wb(8'h12, 1'b1, 8'hfb);
        wb(8'h12, 1'b0, 8'h7b);
        repeat (40) @(posedge clk_i);
        wb(8'h11, 1'b0, 8'h5a);
        cmp(cnt, 8'h5a);
        cmp(lim, 8'hff);
    endtask
    task automatic s_rate;
        wb(8'h92, 1'b1, 8'h02);
        for (int p = 0; p < 4; p++) begin
            wb(8'h12, 1'b1, 8'(4 + p));
            gap(8'h0c << (p > 1 ? 4 : 2 * p));
        end
    endtask
    task automatic s_irq;
        wb(8'h12, 1'b1, 8'h18);
        wb(8'h0c, 1'b1, 8'h02);
        wb(8'h8c, 1'b1, 8'h02);
        wb(8'h12, 1'b1, 8'h1c);
        repeat (3) wm;
        cmp({7'h0, irq}, 8'h00);
        wm;
        repeat (3) @(posedge clk_i);
        cmp({7'h0, irq}, 8'h01);
        wb(8'h12, 1'b1, 8'h00);
        wb(8'h8c, 1'b1, 8'h00);
        @(posedge clk_i);
        cmp({7'h0, irq}, 8'h00);
        wb(8'h0c, 1'b1, 8'h02);
        wb(8'h0c, 1'b0, 8'h00);
    endtask
    task automatic s_hold;
        wb(8'h92, 1'b1, 8'h33);
        wb(8'h12, 1'b1, 8'h04);
        wm;
        ce <= 1'b0;
        repeat (20) @(posedge clk_i);
        cmp(cnt, 8'h00);
        ce <= 1'b1;
        repeat (40) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cmp(cnt, 8'h00);
        cmp(lim, 8'hff);
        wb(8'h12, 1'b0, 8'h00);
    endtask
    task automatic print_verdict;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        s_regs;
        s_rate;
        s_irq;
        s_hold;
        print_verdict;
    end
    initial begin
        #100000 bad_count++;
        print_verdict;
    end
endmodule // pts_timer_tb
